// ### rtl/dcrs_pkg.sv
// shared constants, state type and helpers of the configuration space
package dcrs_pkg;
	// -------------------------------------------------------------
	// configuration port addresses and entry keys
	// -------------------------------------------------------------
	localparam logic [15:0] PORT_STD_IDX = 16'h002E;
	localparam logic [15:0] PORT_STD_DAT = 16'h002F;
	localparam logic [15:0] PORT_ALT_IDX = 16'h004E;
	localparam logic [15:0] PORT_ALT_DAT = 16'h004F;
	localparam logic [7:0]  KEY_CODE0    = 8'h77;
	localparam logic [7:0]  KEY_CODE1    = 8'hA0;
	localparam logic [7:0]  KEY_CODE2    = 8'h87;
	// -------------------------------------------------------------
	// register indices
	// -------------------------------------------------------------
	localparam logic [7:0] IDX_SRST   = 8'h02;
	localparam logic [7:0] IDX_LDN    = 8'h07;
	localparam logic [7:0] IDX_DIDH   = 8'h20;
	localparam logic [7:0] IDX_DIDL   = 8'h21;
	localparam logic [7:0] IDX_VIDH   = 8'h23;
	localparam logic [7:0] IDX_VIDL   = 8'h24;
	localparam logic [7:0] IDX_REFERENCE_CLOCK_SELECT = 8'h25;
	localparam logic [7:0] IDX_WCTL   = 8'h26;
	localparam logic [7:0] IDX_PSEL   = 8'h27;
	localparam logic [7:0] IDX_EN     = 8'h30;
	localparam logic [7:0] IDX_BASEH  = 8'h60;
	localparam logic [7:0] IDX_BASEL  = 8'h61;
	localparam logic [7:0] IDX_IRQ    = 8'h70;
	localparam logic [7:0] IDX_F0     = 8'hF0;
	localparam logic [7:0] IDX_F1     = 8'hF1;
	localparam logic [7:0] IDX_F4     = 8'hF4;
	localparam logic [7:0] IDX_F5     = 8'hF5;
	localparam logic [7:0] IDX_F6     = 8'hF6;
	// -------------------------------------------------------------
	// logical device numbers, field layout and reset values
	// -------------------------------------------------------------
	localparam int         NUM_UART     = 4;
	localparam logic [7:0] LDN_UART_END = 8'h04;
	localparam logic [7:0] LDN_WDT      = 8'h08;
	localparam logic [1:0] CH_FIRST     = 2'h0;
	localparam int         PSEL_PORT    = 4;
	localparam logic [7:0] MASK_IRQ     = 8'h7F;
	localparam logic [7:0] RST_EMF      = 8'h00;
	localparam logic [7:0] RST_IR       = 8'h44;
	localparam logic [7:0] RST_SLV      = 8'h00;
	localparam logic [7:0] RST_MSK      = 8'h00;
	localparam logic [7:0] RST_FIFO     = 8'h00;
	localparam logic       RST_WEN      = 1'b1;
	localparam logic [15:0] RST_WBASE   = 16'h0442;
	localparam logic [7:0] RST_WIRQ     = 8'h00;
	localparam logic [7:0] RST_WSTAT    = 8'h02;
	localparam logic [7:0] RST_WCNT     = 8'h0A;
	localparam int         STRAP_W      = 7;
	localparam logic [2:0] SYNC_FILL    = 3'h4;

	typedef enum logic {
		DCRS_WAIT = 1'b0,
		DCRS_RUN  = 1'b1
	} dcrs_phase_t;

	typedef struct packed {
		dcrs_phase_t                phase;
		logic                       cfg;
		logic [7:0]                 idx;
		logic [7:0]                 logical_device_select;
		logic                       srst;
		logic                       clk48;
		logic [1:0]                 wctl;
		logic                       psel_port;
		logic [1:0]                 psel_key;
		logic [NUM_UART-1:0]        st_en;
		logic [NUM_UART-1:0]        en;
		logic [NUM_UART-1:0][15:0]  base;
		logic [NUM_UART-1:0][7:0]   irq;
		logic [NUM_UART-1:0][7:0]   emf;
		logic [NUM_UART-1:0][7:0]   slv;
		logic [NUM_UART-1:0][7:0]   msk;
		logic [NUM_UART-1:0][7:0]   fifo;
		logic [7:0]                 ir;
		logic                       wen;
		logic [15:0]                wbase;
		logic [7:0]                 wirq;
		logic [7:0]                 wstat;
		logic [7:0]                 wcnt;
		logic [7:0]                 rdata;
		logic                       rvalid;
	} dcrs_state_t;

	// entry key of a key code, top bit marks a valid code
	function automatic logic [8:0] dcrs_key(input logic [1:0] code);
		case (code)
			2'h0:    return {1'b1, KEY_CODE0};
			2'h1:    return {1'b1, KEY_CODE1};
			2'h2:    return {1'b1, KEY_CODE2};
			default: return 9'h000;
		endcase
	endfunction

	// logical device number names a serial channel
	function automatic logic dcrs_is_uart(input logic [7:0] logical_device_select);
		return logical_device_select < LDN_UART_END;
	endfunction
endpackage

// ### rtl/dcrs_sync.sv
// three-stage strap synchroniser with agreement filter
`timescale 1ns/1ps
module dcrs_sync #(
	parameter int W = 7
) (
	// clock, reset, enable
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         ce,
	// pins in, filtered level out
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q,
	output logic              settled
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
		logic [2:0]   cnt;
	} dcrs_sync_t;

	dcrs_sync_t sy_ff;
	dcrs_sync_t nxt_sy;

	// shift chain; s1 feeds only s2
	always_comb begin
		nxt_sy    = sy_ff;
		nxt_sy.s1 = d;
		nxt_sy.s2 = sy_ff.s1;
		nxt_sy.s3 = sy_ff.s2;
		if (sy_ff.s2 == sy_ff.s3) begin
			nxt_sy.q = sy_ff.s3;
		end
		if (sy_ff.cnt != dcrs_pkg::SYNC_FILL) begin
			nxt_sy.cnt = sy_ff.cnt + 3'h1;
		end
	end

	// state register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sy_ff <= '0;
		end else if (ce) begin
			sy_ff <= nxt_sy;
		end
	end

	assign q       = sy_ff.q;
	assign settled = (sy_ff.cnt == dcrs_pkg::SYNC_FILL);
endmodule // dcrs_sync

// ### rtl/dcrs_top.sv
// configuration register space behind the index/data port
`timescale 1ns/1ps
module dcrs_top #(
	parameter logic [7:0] DEV_ID_HIGH = 8'h5A, // arbitrary value
	parameter logic [7:0] DEV_ID_LOW  = 8'h01, // arbitrary value
	parameter logic [7:0] VEN_ID_HIGH = 8'h3C, // arbitrary value
	parameter logic [7:0] VEN_ID_LOW  = 8'h02, // arbitrary value
	parameter logic [7:0] EXIT_KEY    = 8'hAA,
	parameter logic [3:0][15:0] DEF_BASE = {16'h0328, 16'h0320, 16'h0318, 16'h0310},
	parameter logic [3:0][7:0]  DEF_IRQ  = 32'h00000000
) (
	// clock, reset, enable
	input  wire logic        CLK,
	input  wire logic        RST_N,
	input  wire logic        CE,
	// host i/o access
	input  wire logic [15:0] IO_ADDR,
	input  wire logic [7:0]  IO_WDATA,
	input  wire logic        IO_WR,
	input  wire logic        IO_RD,
	output logic      [7:0]  IO_RDATA,
	output logic             IO_RVALID,
	// strapping pins
	input  wire logic        STRAP_PORT_SEL,
	input  wire logic [1:0]  STRAP_KEY,
	input  wire logic [3:0]  STRAP_UART_EN,
	// global settings
	output logic             CFG_ACTIVE,
	output logic             REF_CLK_48M,
	output logic      [1:0]  WDT_CTRL,
	// serial channel settings
	output logic      [3:0]  UART_EN,
	output logic      [63:0] UART_BASE,
	output logic      [31:0] UART_IRQ,
	output logic      [31:0] UART_EMF,
	output logic      [31:0] UART_SLV,
	output logic      [31:0] UART_MASK,
	output logic      [31:0] UART_FIFO,
	output logic      [7:0]  IR_CTRL,
	// watchdog settings
	output logic             WDT_EN,
	output logic      [15:0] WDT_BASE,
	output logic      [7:0]  WDT_IRQ,
	output logic      [7:0]  WDT_STAT,
	output logic      [7:0]  WDT_COUNT
);
	// -------------------------------------------------------------
	// declarations
	// -------------------------------------------------------------
	dcrs_pkg::dcrs_state_t st_ff;
	dcrs_pkg::dcrs_state_t nxt_st;
	logic [dcrs_pkg::STRAP_W-1:0] strap_q;
	logic        strap_ok;
	logic        is_idx;
	logic        is_dat;
	logic        uart_sel;
	logic        wdt_sel;
	logic [1:0]  ch;
	logic [8:0]  kv;
	logic [7:0]  rv;
	logic [7:0]  wd;
	logic        wr_idx;
	logic        wr_dat;
	logic        rd_dat;
	logic        load;

	// strap pins cross in through three stages
	dcrs_sync #(
		.W (dcrs_pkg::STRAP_W)
	) u_sync (
		.clk     (CLK),
		.rst_n   (RST_N),
		.ce      (CE),
		.d       ({STRAP_PORT_SEL, STRAP_KEY, STRAP_UART_EN}),
		.q       (strap_q),
		.settled (strap_ok)
	);

	// -------------------------------------------------------------
	// next-state logic
	// -------------------------------------------------------------
	always_comb begin
		nxt_st        = st_ff;
		nxt_st.rvalid = 1'b0;
		wd            = IO_WDATA;
		ch            = st_ff.logical_device_select[1:0];
		uart_sel      = dcrs_pkg::dcrs_is_uart(st_ff.logical_device_select);
		wdt_sel       = (st_ff.logical_device_select == dcrs_pkg::LDN_WDT);
		kv            = dcrs_pkg::dcrs_key(st_ff.psel_key);
		// port pair follows the select bit
		is_idx = st_ff.psel_port ? (IO_ADDR == dcrs_pkg::PORT_ALT_IDX)
		                         : (IO_ADDR == dcrs_pkg::PORT_STD_IDX);
		is_dat = st_ff.psel_port ? (IO_ADDR == dcrs_pkg::PORT_ALT_DAT)
		                         : (IO_ADDR == dcrs_pkg::PORT_STD_DAT);
		wr_idx = IO_WR && is_idx && (st_ff.phase == dcrs_pkg::DCRS_RUN);
		wr_dat = IO_WR && is_dat && st_ff.cfg && (st_ff.phase == dcrs_pkg::DCRS_RUN);
		rd_dat = IO_RD && is_dat && st_ff.cfg && (st_ff.phase == dcrs_pkg::DCRS_RUN);
		load   = st_ff.srst || ((st_ff.phase == dcrs_pkg::DCRS_WAIT) && strap_ok);

		// read mux; reserved bits and unassigned devices read zero
		case (st_ff.idx)
			dcrs_pkg::IDX_SRST:   rv = {7'h00, st_ff.srst};
			dcrs_pkg::IDX_LDN:    rv = st_ff.logical_device_select;
			dcrs_pkg::IDX_DIDH:   rv = DEV_ID_HIGH;
			dcrs_pkg::IDX_DIDL:   rv = DEV_ID_LOW;
			dcrs_pkg::IDX_VIDH:   rv = VEN_ID_HIGH;
			dcrs_pkg::IDX_VIDL:   rv = VEN_ID_LOW;
			dcrs_pkg::IDX_REFERENCE_CLOCK_SELECT: rv = {7'h00, st_ff.clk48};
			dcrs_pkg::IDX_WCTL:   rv = {6'h00, st_ff.wctl};
			dcrs_pkg::IDX_PSEL:   rv = {3'h0, st_ff.psel_port, 2'h0, st_ff.psel_key};
			dcrs_pkg::IDX_EN:     rv = uart_sel ? {7'h00, st_ff.en[ch]} :
			                           wdt_sel ? {7'h00, st_ff.wen} : 8'h00;
			dcrs_pkg::IDX_BASEH:  rv = uart_sel ? st_ff.base[ch][15:8] :
			                           wdt_sel ? st_ff.wbase[15:8] : 8'h00;
			dcrs_pkg::IDX_BASEL:  rv = uart_sel ? st_ff.base[ch][7:0] :
			                           wdt_sel ? st_ff.wbase[7:0] : 8'h00;
			dcrs_pkg::IDX_IRQ:    rv = uart_sel ? st_ff.irq[ch] :
			                           wdt_sel ? st_ff.wirq : 8'h00;
			dcrs_pkg::IDX_F0:     rv = uart_sel ? st_ff.emf[ch] :
			                           wdt_sel ? st_ff.wstat : 8'h00;
			dcrs_pkg::IDX_F1:     rv = (uart_sel && ch == dcrs_pkg::CH_FIRST) ? st_ff.ir :
			                           wdt_sel ? st_ff.wcnt : 8'h00;
			dcrs_pkg::IDX_F4:     rv = uart_sel ? st_ff.slv[ch] : 8'h00;
			dcrs_pkg::IDX_F5:     rv = uart_sel ? st_ff.msk[ch] : 8'h00;
			dcrs_pkg::IDX_F6:     rv = uart_sel ? st_ff.fifo[ch] : 8'h00;
			default:              rv = 8'h00;
		endcase

		// index port: entry key, exit key or register index
		if (wr_idx) begin
			if (!st_ff.cfg) begin
				if (kv[8] && (wd == kv[7:0])) begin
					nxt_st.cfg = 1'b1;
				end
			end else if (wd == EXIT_KEY) begin
				nxt_st.cfg = 1'b0;
			end else begin
				nxt_st.idx = wd;
			end
		end

		// data port writes; ident registers have no write path
		if (wr_dat) begin
			case (st_ff.idx)
				dcrs_pkg::IDX_SRST:   nxt_st.srst = wd[0];
				dcrs_pkg::IDX_LDN:    nxt_st.logical_device_select = wd;
				dcrs_pkg::IDX_REFERENCE_CLOCK_SELECT: nxt_st.clk48 = wd[0];
				dcrs_pkg::IDX_WCTL:   nxt_st.wctl = wd[1:0];
				dcrs_pkg::IDX_PSEL: begin
					nxt_st.psel_port = wd[dcrs_pkg::PSEL_PORT];
					nxt_st.psel_key  = wd[1:0];
				end
				dcrs_pkg::IDX_EN: begin
					if (uart_sel) begin
						nxt_st.en[ch] = wd[0];
					end else if (wdt_sel) begin
						nxt_st.wen = wd[0];
					end
				end
				dcrs_pkg::IDX_BASEH: begin
					if (uart_sel) begin
						nxt_st.base[ch][15:8] = wd;
					end else if (wdt_sel) begin
						nxt_st.wbase[15:8] = wd;
					end
				end
				dcrs_pkg::IDX_BASEL: begin
					if (uart_sel) begin
						nxt_st.base[ch][7:0] = wd;
					end else if (wdt_sel) begin
						nxt_st.wbase[7:0] = wd;
					end
				end
				dcrs_pkg::IDX_IRQ: begin
					if (uart_sel) begin
						nxt_st.irq[ch] = wd & dcrs_pkg::MASK_IRQ;
					end else if (wdt_sel) begin
						nxt_st.wirq = wd & dcrs_pkg::MASK_IRQ;
					end
				end
				dcrs_pkg::IDX_F0: begin
					if (uart_sel) begin
						nxt_st.emf[ch] = wd;
					end else if (wdt_sel) begin
						nxt_st.wstat = wd;
					end
				end
				dcrs_pkg::IDX_F1: begin
					if (uart_sel && ch == dcrs_pkg::CH_FIRST) begin
						nxt_st.ir = wd;
					end else if (wdt_sel) begin
						nxt_st.wcnt = wd;
					end
				end
				dcrs_pkg::IDX_F4: begin
					if (uart_sel) begin
						nxt_st.slv[ch] = wd;
					end
				end
				dcrs_pkg::IDX_F5: begin
					if (uart_sel) begin
						nxt_st.msk[ch] = wd;
					end
				end
				dcrs_pkg::IDX_F6: begin
					if (uart_sel) begin
						nxt_st.fifo[ch] = wd;
					end
				end
				default: ;
			endcase
		end

		// first strap capture after power-up; global straps only here
		if ((st_ff.phase == dcrs_pkg::DCRS_WAIT) && strap_ok) begin
			nxt_st.phase     = dcrs_pkg::DCRS_RUN;
			nxt_st.psel_port = strap_q[6];
			nxt_st.psel_key  = strap_q[5:4];
			nxt_st.st_en     = strap_q[3:0];
		end

		// factory defaults for every per-device register set
		if (load) begin
			nxt_st.srst  = 1'b0;
			nxt_st.en    = st_ff.srst ? st_ff.st_en : strap_q[3:0];
			nxt_st.base  = DEF_BASE;
			nxt_st.irq   = DEF_IRQ;
			nxt_st.emf   = {dcrs_pkg::NUM_UART{dcrs_pkg::RST_EMF}};
			nxt_st.slv   = {dcrs_pkg::NUM_UART{dcrs_pkg::RST_SLV}};
			nxt_st.msk   = {dcrs_pkg::NUM_UART{dcrs_pkg::RST_MSK}};
			nxt_st.fifo  = {dcrs_pkg::NUM_UART{dcrs_pkg::RST_FIFO}};
			nxt_st.ir    = dcrs_pkg::RST_IR;
			nxt_st.wen   = dcrs_pkg::RST_WEN;
			nxt_st.wbase = dcrs_pkg::RST_WBASE;
			nxt_st.wirq  = dcrs_pkg::RST_WIRQ;
			nxt_st.wstat = dcrs_pkg::RST_WSTAT;
			nxt_st.wcnt  = dcrs_pkg::RST_WCNT;
		end

		// read answer one cycle later; unclaimed reads give zero
		if (IO_RD) begin
			nxt_st.rvalid = 1'b1;
			nxt_st.rdata  = rd_dat ? rv :
			                (IO_RD && is_idx && st_ff.cfg) ? st_ff.idx : 8'h00;
		end
	end

	// state register, frozen while the enable is low
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			st_ff <= '0;
		end else if (CE) begin
			st_ff <= nxt_st;
		end
	end

	// -------------------------------------------------------------
	// outputs straight from the state register
	// -------------------------------------------------------------
	assign IO_RDATA    = st_ff.rdata;
	assign IO_RVALID   = st_ff.rvalid;
	assign CFG_ACTIVE  = st_ff.cfg;
	assign REF_CLK_48M = st_ff.clk48;
	assign WDT_CTRL    = st_ff.wctl;
	assign UART_EN     = st_ff.en;
	assign UART_BASE   = st_ff.base;
	assign UART_IRQ    = st_ff.irq;
	assign UART_EMF    = st_ff.emf;
	assign UART_SLV    = st_ff.slv;
	assign UART_MASK   = st_ff.msk;
	assign UART_FIFO   = st_ff.fifo;
	assign IR_CTRL     = st_ff.ir;
	assign WDT_EN      = st_ff.wen;
	assign WDT_BASE    = st_ff.wbase;
	assign WDT_IRQ     = st_ff.wirq;
	assign WDT_STAT    = st_ff.wstat;
	assign WDT_COUNT   = st_ff.wcnt;

	// -------------------------------------------------------------
	// assertions
	// -------------------------------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	sequence srst_wr_s;
		CE && wr_dat && !load && (st_ff.idx == dcrs_pkg::IDX_SRST) && IO_WDATA[0];
	endsequence

	sequence srst_done_s;
		!st_ff.srst && (WDT_COUNT == dcrs_pkg::RST_WCNT) && (UART_SLV == '0);
	endsequence

	sequence key_wr_s;
		CE && wr_idx && !st_ff.cfg && kv[8] && (IO_WDATA == kv[7:0]);
	endsequence

	sw_reset_load_a: assert property (srst_wr_s ##1 CE |=> srst_done_s)
		else $error("software reset did not reload defaults");
	strap_keep_a: assert property (srst_wr_s ##1 CE |=> UART_EN == st_ff.st_en)
		else $error("software reset lost captured straps");
	srst_clear_a: assert property (srst_wr_s |=> st_ff.srst ##1 (!CE || !st_ff.srst))
		else $error("software reset bit did not self clear");
	dev_ident_a: assert property (CE && rd_dat && st_ff.idx == dcrs_pkg::IDX_DIDH
		|=> IO_RVALID && IO_RDATA == DEV_ID_HIGH)
		else $error("device ident high wrong");
	ven_ident_a: assert property (CE && rd_dat && st_ff.idx == dcrs_pkg::IDX_VIDL
		|=> IO_RVALID && IO_RDATA == VEN_ID_LOW)
		else $error("vendor ident low wrong");
	wdt_route_a: assert property (CE && wr_dat && st_ff.idx == dcrs_pkg::IDX_EN && wdt_sel
		&& !load |=> WDT_EN == $past(IO_WDATA[0]) && $stable(UART_EN))
		else $error("watchdog enable write misrouted");
	clk_select_a: assert property (CE && wr_dat && st_ff.idx == dcrs_pkg::IDX_REFERENCE_CLOCK_SELECT
		|=> REF_CLK_48M == $past(IO_WDATA[0]))
		else $error("clock select not stored");
	unassigned_ldn_a: assert property (CE && rd_dat && st_ff.idx == dcrs_pkg::IDX_BASEH
		&& !uart_sel && !wdt_sel |=> IO_RDATA == 8'h00)
		else $error("unassigned device read not zero");
	reserved_zero_a: assert property (CE && rd_dat && st_ff.idx == dcrs_pkg::IDX_PSEL
		|=> IO_RDATA[7:5] == 3'h0 && IO_RDATA[3:2] == 2'h0)
		else $error("reserved port select bits not zero");
	entry_key_a: assert property (key_wr_s |=> CFG_ACTIVE)
		else $error("entry key did not open configuration");
	other_port_a: assert property (CE && !st_ff.cfg && IO_WR && !is_idx |=> !CFG_ACTIVE)
		else $error("configuration opened from wrong port");
endmodule // dcrs_top

// ### verif/dcrs_host.sv
// host model that drives the configuration index/data port
`timescale 1ns/1ps
module dcrs_host (
	// clock
	input  wire logic        CLK,
	// host i/o access
	output logic      [15:0] IO_ADDR,
	output logic      [7:0]  IO_WDATA,
	output logic             IO_WR,
	output logic             IO_RD,
	input  wire logic [7:0]  IO_RDATA,
	input  wire logic        IO_RVALID
);
	initial begin
		IO_ADDR  = 16'h0000;
		IO_WDATA = 8'h00;
		IO_WR    = 1'b0;
		IO_RD    = 1'b0;
	end

	// one write strobe; released lines show the inverse of the last value
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge CLK);
		IO_ADDR  = a;
		IO_WDATA = d;
		IO_WR    = 1'b1;
		@(negedge CLK);
		IO_WR    = 1'b0;
		IO_ADDR  = ~a;
		IO_WDATA = ~d;
	endtask

	// one read strobe; answer awaited for two cycles at most
	task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic ok);
		@(negedge CLK);
		IO_ADDR = a;
		IO_RD   = 1'b1;
		@(negedge CLK);
		IO_RD   = 1'b0;
		IO_ADDR = ~a;
		ok      = IO_RVALID;
		if (ok !== 1'b1) begin
			@(negedge CLK);
			ok = IO_RVALID;
		end
		d = IO_RDATA;
	endtask
endmodule // dcrs_host

// ### verif/dcrs_top_tb.sv
// self-checking bench of the configuration register space
`timescale 1ns/1ps
module dcrs_top_tb;
	// ---------------------------------------------------------
	// tables and stimulus state
	// ---------------------------------------------------------
	localparam logic [7:0] IDV [4]  = '{8'hC5, 8'h19, 8'h6E, 8'hB3}; // arbitrary values
	localparam logic [7:0] IDI [4]  = '{8'h20, 8'h21, 8'h23, 8'h24};
	localparam logic [7:0] IDXS [9] = '{8'h30, 8'h60, 8'h61, 8'h70, 8'hF0, 8'hF1, 8'hF4, 8'hF5, 8'hF6};
	localparam logic [7:0] WDEF [9] = '{8'h01, 8'h04, 8'h42, 8'h00, 8'h02, 8'h0A, 8'h00, 8'h00, 8'h00};
	localparam logic [7:0] LDNS [6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h08, 8'h05};
	localparam logic [7:0] KEYS [3] = '{8'h77, 8'hA0, 8'h87};
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        s_port;
	logic [1:0]  s_key;
	logic [3:0]  s_en;
	logic [3:0]  cap_en;
	logic [15:0] io_addr;
	logic [7:0]  io_wdata;
	logic        io_wr;
	logic        io_rd;
	logic [7:0]  io_rdata;
	logic        io_rvalid;
	logic        cfg_active;
	logic        ref_48m;
	logic [31:0] uart_slv;
	logic [7:0]  wdt_count;
	logic [15:0] p_idx;
	logic [7:0]  d;
	logic [7:0]  w;
	logic [7:0]  ow;
	logic        ok;
	logic        ce = 1'b1;
	logic [1:0]  wdt_ctrl;
	logic [3:0]  uart_en;
	logic [63:0] uart_base;
	logic [31:0] uart_irq;
	logic [31:0] uart_emf;
	logic [31:0] uart_mask;
	logic [31:0] uart_fifo;
	logic [7:0]  ir_ctrl;
	logic        wdt_en;
	logic [15:0] wdt_base;
	logic [7:0]  wdt_irq;
	logic [7:0]  wdt_stat;
	logic [7:0]  e;
	int          fail_count = 0;
	int          compares = 0;

	always #10 clk = ~clk;

	dcrs_host host (.CLK(clk), .IO_ADDR(io_addr), .IO_WDATA(io_wdata), .IO_WR(io_wr),
		.IO_RD(io_rd), .IO_RDATA(io_rdata), .IO_RVALID(io_rvalid));

	dcrs_top #(.DEV_ID_HIGH(IDV[0]), .DEV_ID_LOW(IDV[1]), .VEN_ID_HIGH(IDV[2]),
		.VEN_ID_LOW(IDV[3])) uut (.CLK(clk), .RST_N(rst_n), .CE(ce), .IO_ADDR(io_addr),
		.IO_WDATA(io_wdata), .IO_WR(io_wr), .IO_RD(io_rd), .IO_RDATA(io_rdata),
		.IO_RVALID(io_rvalid), .STRAP_PORT_SEL(s_port), .STRAP_KEY(s_key),
		.STRAP_UART_EN(s_en), .CFG_ACTIVE(cfg_active), .REF_CLK_48M(ref_48m),
		.WDT_CTRL(wdt_ctrl), .UART_EN(uart_en), .UART_BASE(uart_base), .UART_IRQ(uart_irq),
		.UART_EMF(uart_emf), .UART_SLV(uart_slv), .UART_MASK(uart_mask),
		.UART_FIFO(uart_fifo), .IR_CTRL(ir_ctrl), .WDT_EN(wdt_en), .WDT_BASE(wdt_base),
		.WDT_IRQ(wdt_irq), .WDT_STAT(wdt_stat), .WDT_COUNT(wdt_count));

	// ---------------------------------------------------------
	// expectations and access helpers
	// ---------------------------------------------------------
	function automatic logic [7:0] exp_def(input logic [7:0] logical_device_select, input int k);
		logic [15:0] b;
		b = 16'h0310 + 16'(logical_device_select) * 16'h0008;
		if (logical_device_select == 8'h08) return WDEF[k];
		if (logical_device_select > 8'h03) return 8'h00;
		case (k)
			0: return {7'h00, cap_en[logical_device_select[1:0]]};
			1: return b[15:8];
			2: return b[7:0];
			5: return (logical_device_select == 8'h00) ? 8'h44 : 8'h00;
			default: return 8'h00;
		endcase
	endfunction

	// settings output byte that mirrors a per-device register
	function automatic logic [7:0] out_byte(input logic [7:0] logical_device_select, input int k);
		int c;
		c = int'(logical_device_select[1:0]);
		if (logical_device_select == 8'h08) begin
			case (k)
				0: return {7'h00, wdt_en};
				1: return wdt_base[15:8];
				2: return wdt_base[7:0];
				3: return wdt_irq;
				4: return wdt_stat;
				5: return wdt_count;
				default: return 8'h00;
			endcase
		end
		case (k)
			0: return {7'h00, uart_en[c]};
			1: return uart_base[16 * c + 8 +: 8];
			2: return uart_base[16 * c +: 8];
			3: return uart_irq[8 * c +: 8];
			4: return uart_emf[8 * c +: 8];
			5: return (c == 0) ? ir_ctrl : 8'h00;
			6: return uart_slv[8 * c +: 8];
			7: return uart_mask[8 * c +: 8];
			default: return uart_fifo[8 * c +: 8];
		endcase
	endfunction

	// writable bits of a per-device register
	function automatic logic [7:0] wmask(input logic [7:0] logical_device_select, input int k);
		if (logical_device_select > 8'h03 && logical_device_select != 8'h08) return 8'h00;
		if (k == 0) return 8'h01;
		if (k == 3) return 8'h7F;
		if (logical_device_select == 8'h08 && k > 5) return 8'h00;
		if (logical_device_select != 8'h08 && logical_device_select != 8'h00 && k == 5) return 8'h00;
		return 8'hFF;
	endfunction

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr_reg(input logic [7:0] i, input logic [7:0] v);
		host.wr(p_idx, i);
		host.wr(p_idx + 16'h0001, v);
	endtask

	task automatic rd_reg(input logic [7:0] i, output logic [7:0] v);
		logic a;
		host.wr(p_idx, i);
		host.rd(p_idx + 16'h0001, v, a);
		check({7'h00, a}, 8'h01);
	endtask

	task automatic check_defaults;
		foreach (LDNS[n]) begin
			wr_reg(8'h07, LDNS[n]);
			for (int k = 0; k < 9; k++) begin
				rd_reg(IDXS[k], d);
				check(d, exp_def(LDNS[n], k));
				if (LDNS[n] != 8'h05) check(out_byte(LDNS[n], k), exp_def(LDNS[n], k));
			end
		end
	endtask

	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		#400000;
		fail_count++;
		$display("unexpected timeout at %0t", $time);
		finish_test();
	end

	// ---------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------
	initial begin
		void'($urandom(32'h50F7A06A));
		s_port = 1'($urandom);
		s_key  = 2'($urandom_range(2, 0));
		s_en   = 4'($urandom);
		cap_en = s_en;
		p_idx  = s_port ? 16'h004E : 16'h002E;
		repeat (8) @(negedge clk);
		rst_n = 1'b1;
		repeat (10) @(negedge clk);
		// entry only with the selected key at the strapped port
		host.wr(p_idx ^ 16'h0060, KEYS[s_key]);
		check({7'h00, cfg_active}, 8'h00);
		host.wr(p_idx, KEYS[(s_key + 2'h1) % 3]);
		check({7'h00, cfg_active}, 8'h00);
		host.wr(p_idx, KEYS[s_key]);
		check({7'h00, cfg_active}, 8'h01);
		check_defaults();
		// identification is fixed and ignores writes
		foreach (IDI[j]) begin
			wr_reg(IDI[j], 8'hFF);
			rd_reg(IDI[j], d);
			check(d, IDV[j]);
		end
		// random read/write through every device set
		foreach (LDNS[n]) begin
			wr_reg(8'h07, LDNS[n]);
			for (int k = 0; k < 9; k++) begin
				w = 8'($urandom);
				if (k == (LDNS[n] == 8'h08 ? 5 : 6)) ow = w;
				wr_reg(IDXS[k], w);
				rd_reg(IDXS[k], d);
				e = (w & wmask(LDNS[n], k)) | (exp_def(LDNS[n], k) & ~wmask(LDNS[n], k));
				check(d, e);
				if (LDNS[n] != 8'h05) check(out_byte(LDNS[n], k), e);
			end
			if (LDNS[n] < 8'h04) check(uart_slv[8 * LDNS[n][1:0] +: 8], ow);
			if (LDNS[n] == 8'h08) check(wdt_count, ow);
		end
		// clock select bit and its reserved bits
		wr_reg(8'h25, 8'hFF);
		check({7'h00, ref_48m}, 8'h01);
		rd_reg(8'h25, d);
		check(d, 8'h01);
		wr_reg(8'h25, 8'h00);
		check({7'h00, ref_48m}, 8'h00);
		// global watchdog control keeps two bits only
		wr_reg(8'h26, 8'hFF);
		rd_reg(8'h26, d);
		check(d, 8'h03);
		check({6'h00, wdt_ctrl}, 8'h03);
		// software reset with the strap pins moved meanwhile
		s_en = ~s_en;
		wr_reg(8'h02, 8'hFF);
		rd_reg(8'h02, d);
		check(d, 8'h00);
		check_defaults();
		// a frozen block ignores the exit key
		ce = 1'b0;
		host.wr(p_idx, 8'hAA);
		check({7'h00, cfg_active}, 8'h01);
		ce = 1'b1;
		// move the port pair, pick the keyless code, then leave configuration mode
		wr_reg(8'h27, {3'h0, ~s_port, 2'h0, 2'h3});
		host.rd(p_idx, d, ok);
		check(d, 8'h00);
		p_idx = p_idx ^ 16'h0060;
		host.rd(p_idx, d, ok);
		check(d, 8'h27);
		host.wr(p_idx, 8'hAA);
		check({7'h00, cfg_active}, 8'h00);
		// key code 11 accepts none of the entry keys
		foreach (KEYS[j]) begin
			host.wr(p_idx, KEYS[j]);
			check({7'h00, cfg_active}, 8'h00);
		end
		finish_test();
	end
endmodule // dcrs_top_tb
